// >>> inc/audio_clk_pkg.sv
// constants shared by the serial audio port clock monitor and source control
// assumes a 250 MHz system clock sampling the port pins
package audio_clk_pkg;

    // system clock and stopped-clock timeout
    localparam int CLK_MHZ        = 250;
    localparam int TIMEOUT_US     = 160;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

    // register offsets
    localparam logic [7:0] STATUS_OFFSET = 8'h15;
    localparam logic [7:0] SOURCE_OFFSET = 8'h16;
    localparam logic [7:0] MODE_OFFSET   = 8'h17;

    // values after reset
    localparam logic [7:0] STATUS_RESET = 8'hFF;
    localparam logic [7:0] SOURCE_RESET = 8'h10;
    localparam logic [7:0] MODE_RESET   = 8'h02;

    // clock_source_config fields
    localparam int SRC_ROOT_BIT   = 7;
    localparam int SRC_SPEC_BIT   = 6;
    localparam int SRC_RATIO_LSB  = 3;
    localparam int SRC_INVERT_BIT = 1;

    // mode_config fields
    localparam int MODE_MASTER_BIT  = 7;
    localparam int MODE_MANUAL_BIT  = 6;
    localparam int MODE_PLL_OFF_BIT = 5;
    localparam int MODE_FREQ_LSB    = 0;

    // status codes
    localparam logic [3:0] INVALID_CODE = 4'hF;
    localparam int         RATE_COUNT   = 9;
    localparam int         RATIO_COUNT  = 13;

    // frame period windows in system clocks, code 8 leftmost down to code 0
    localparam logic [RATE_COUNT-1:0][15:0] RATE_MIN = {
        16'h0138, 16'h0271, 16'h04E2, 16'h09C4, 16'h1388,
        16'h1D4C, 16'h2710, 16'h3A98, 16'h7530};
    localparam logic [RATE_COUNT-1:0][15:0] RATE_MAX = {
        16'h0171, 16'h02E2, 16'h05C3, 16'h0B86, 16'h170C,
        16'h2292, 16'h2E18, 16'h4524, 16'h8A48};

    // bit clocks per frame, code 12 leftmost down to code 0
    localparam logic [RATIO_COUNT-1:0][11:0] RATIO_TABLE = {
        12'h800, 12'h400, 12'h200, 12'h180, 12'h100, 12'h0C0, 12'h080,
        12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010};

    // master clock to frame ratios, code 7 leftmost down to code 0
    localparam logic [7:0][11:0] MCLK_RATIO_TABLE = {
        12'h900, 12'h600, 12'h400, 12'h300,
        12'h200, 12'h180, 12'h100, 12'h040};

    // master mode generator defaults
    localparam int BCLK_HALF_CYCLES = 20;
    localparam int FRAME_BCLKS      = 64;

endpackage

// >>> inc/monitor_if.sv
// edge events and measured codes passed between port logic and rate meter
// assumes one clock domain: the system clock
`timescale 1ns/1ps
interface monitor_if;
    logic       bclk_rise;
    logic       frame_sync_rise;
    logic [3:0] rate_code;
    logic [3:0] ratio_code;

    modport port  (output bclk_rise, output frame_sync_rise, input rate_code, input ratio_code);
    modport meter (input bclk_rise, input frame_sync_rise, output rate_code, output ratio_code);
endinterface

// >>> src/audio_clock_ctrl.sv
// serial audio port clock monitor and clock source control
// assumes registers reached over a plain strobe port on clk_in;
// bit clock and frame sync pins are asynchronous and sampled here
//
// Summary of operation
// - status bits 7-4 report measured frame rate family, codes 0 to 8
// - frame rate matching no supported family reports code 15
// - rate codes 9 to 14 are never reported
// - status bits 3-0 report bit clocks per frame, codes 0 to 12
// - ratio codes 13, 14 unused; invalid ratio reports code 15
// - status register at 0x15 is read-only and resets to 0xFF
// - slave, auto, pll off: bit 7 picks bit clock or master clock root
// - master clock root takes its frame ratio from the ratio field
// - auto setup only: bit 6 picks absolute frequency or frame multiple for master clock
// - ratio field bits 5-3 encode 64 up to 2304
// - ratio field applies in master mode or with master clock root
// - source register at 0x16 resets to 0x10
// - bit 1 inverts bit clock edge used for frame generation
// - pll off control in slave auto setup enables root clock select
// - slave mode takes both clocks in; master mode drives both out
`timescale 1ns/1ps
module audio_clock_ctrl
    import audio_clk_pkg::*;
#(
    parameter int TIMEOUT    = TIMEOUT_CYCLES,
    parameter int BCLK_HALF  = BCLK_HALF_CYCLES,
    parameter int FRAME_BITS = FRAME_BCLKS
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        bit_clk_in,
    input  wire logic        frame_sync_in,
    output logic             bit_clk_out,
    output logic             bit_clk_oe_out,
    output logic             frame_sync_out,
    output logic             frame_sync_oe_out,
    output logic             root_clk_select_out,
    output logic             mclk_ratio_apply_out,
    output logic      [11:0] mclk_ratio_out,
    output logic             mclk_freq_spec_out,
    output logic      [2:0]  mclk_freq_code_out
);
    monitor_if mon ();

    logic [1:0] pins_sync;
    logic [1:0] pins_prev;

    logic [7:0] clock_source_config, next_clock_source_config;
    logic [7:0] mode_config,         next_mode_config;
    logic [7:0] next_rdata;

    logic       master_mode;
    logic       auto_setup;
    logic       auto_setup_pll_off;
    logic       root_clock_select;
    logic       master_freq_spec_mode;
    logic [2:0] ratio_select;
    logic [2:0] master_absolute_freq_select;
    logic       frame_gen_edge_invert;

    logic        next_root_sel;
    logic        next_ratio_apply;
    logic [11:0] next_ratio_value;
    logic        next_freq_spec;
    logic [2:0]  next_freq_code;

    logic [15:0] div_cnt,   next_div_cnt;
    logic        bclk_gen,  next_bclk_gen;
    logic [11:0] bit_cnt,   next_bit_cnt;
    logic        frame_sync_gen, next_frame_sync_gen;
    logic        frame_edge;

    // synchronise pins: bit 1 bit clock, bit 0 frame sync
    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in ({bit_clk_in, frame_sync_in}),
        .sync_out (pins_sync)
    );

    // previous synchronised level for edge detection
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pins_prev <= 2'b00;
        end else begin
            pins_prev <= pins_sync;
        end
    end

    // one-cycle rise pulses towards the meter
    assign mon.bclk_rise  = pins_sync[1] & ~pins_prev[1];
    assign mon.frame_sync_rise = pins_sync[0] & ~pins_prev[0];

    rate_meter #(
        .TIMEOUT (TIMEOUT)
    ) u_meter (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .mon      (mon.meter)
    );

    // field views of the writable registers
    assign root_clock_select           = clock_source_config[SRC_ROOT_BIT];
    assign master_freq_spec_mode       = clock_source_config[SRC_SPEC_BIT];
    assign ratio_select                = clock_source_config[SRC_RATIO_LSB +: 3];
    assign frame_gen_edge_invert       = clock_source_config[SRC_INVERT_BIT];
    assign master_mode                 = mode_config[MODE_MASTER_BIT];
    assign auto_setup                  = ~mode_config[MODE_MANUAL_BIT];
    assign auto_setup_pll_off          = mode_config[MODE_PLL_OFF_BIT];
    assign master_absolute_freq_select = mode_config[MODE_FREQ_LSB +: 3];

    // register writes; status has no write path
    always_comb begin
        next_clock_source_config = clock_source_config;
        next_mode_config         = mode_config;
        if (reg_wr_in) begin
            if (reg_addr_in == SOURCE_OFFSET) begin
                next_clock_source_config = reg_wdata_in;  // reserved bits kept as written
            end else if (reg_addr_in == MODE_OFFSET) begin
                next_mode_config = reg_wdata_in;
            end
        end
    end

    // register read data, zero for unmapped addresses
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in) begin
            if (reg_addr_in == STATUS_OFFSET) begin
                next_rdata = {mon.rate_code, mon.ratio_code};
            end else if (reg_addr_in == SOURCE_OFFSET) begin
                next_rdata = clock_source_config;
            end else if (reg_addr_in == MODE_OFFSET) begin
                next_rdata = mode_config;
            end
        end
    end

    // register file
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_source_config <= SOURCE_RESET;
            mode_config         <= MODE_RESET;
            reg_rdata_out       <= 8'h00;
        end else begin
            clock_source_config <= next_clock_source_config;
            mode_config         <= next_mode_config;
            reg_rdata_out       <= next_rdata;
        end
    end

    // clock source decode
    always_comb begin
        // root select only honoured in slave auto setup with pll off
        next_root_sel = ~master_mode & auto_setup & auto_setup_pll_off
                        & root_clock_select;
        // ratio used in master mode or with master clock root
        next_ratio_apply = master_mode | next_root_sel;
        next_ratio_value = next_ratio_apply ? MCLK_RATIO_TABLE[ratio_select]
                                            : 12'h000;
        // frequency given as absolute code or frame multiple
        next_freq_spec = auto_setup & master_freq_spec_mode;
        next_freq_code = next_freq_spec ? ratio_select : master_absolute_freq_select;
    end

    // registered decode outputs
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            root_clk_select_out  <= 1'b0;
            mclk_ratio_apply_out <= 1'b0;
            mclk_ratio_out       <= 12'h000;
            mclk_freq_spec_out   <= 1'b0;
            mclk_freq_code_out   <= 3'h0;
        end else begin
            root_clk_select_out  <= next_root_sel;
            mclk_ratio_apply_out <= next_ratio_apply;
            mclk_ratio_out       <= next_ratio_value;
            mclk_freq_spec_out   <= next_freq_spec;
            mclk_freq_code_out   <= next_freq_code;
        end
    end

    // frame sync moves on bit clock fall, or on rise when inverted
    assign frame_edge = (div_cnt == 16'(BCLK_HALF - 1))
                        & (bclk_gen ^ frame_gen_edge_invert);

    // master mode bit clock divider and frame sync generator
    always_comb begin
        next_div_cnt   = div_cnt;
        next_bclk_gen  = bclk_gen;
        next_bit_cnt   = bit_cnt;
        next_frame_sync_gen = frame_sync_gen;
        if (!master_mode) begin
            next_div_cnt   = '0;
            next_bclk_gen  = 1'b0;
            next_bit_cnt   = '0;
            next_frame_sync_gen = 1'b0;
        end else if (div_cnt == 16'(BCLK_HALF - 1)) begin
            next_div_cnt  = '0;
            next_bclk_gen = ~bclk_gen;
            if (frame_edge) begin
                // one bit clock wide pulse at each frame start
                next_frame_sync_gen = (bit_cnt == 12'(FRAME_BITS - 1));
                next_bit_cnt   = (bit_cnt == 12'(FRAME_BITS - 1)) ? 12'h000
                                                                  : bit_cnt + 12'h001;
            end
        end else begin
            next_div_cnt = div_cnt + 16'h0001;
        end
    end

    // generator state and pin drives
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_cnt           <= '0;
            bclk_gen          <= 1'b0;
            bit_cnt           <= '0;
            frame_sync_gen         <= 1'b0;
            bit_clk_out       <= 1'b0;
            frame_sync_out    <= 1'b0;
            bit_clk_oe_out    <= 1'b0;
            frame_sync_oe_out <= 1'b0;
        end else begin
            div_cnt           <= next_div_cnt;
            bclk_gen          <= next_bclk_gen;
            bit_cnt           <= next_bit_cnt;
            frame_sync_gen         <= next_frame_sync_gen;
            bit_clk_out       <= next_bclk_gen;
            frame_sync_out    <= next_frame_sync_gen;
            bit_clk_oe_out    <= master_mode;  // slave leaves pins to host
            frame_sync_oe_out <= master_mode;
        end
    end
endmodule

// >>> src/pin_sync.sv
// two-flop synchroniser for a group of pins
// assumes inputs are asynchronous to clk_in
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> src/rate_meter.sv
// measures frame period and bit clocks per frame, classifies into codes
// assumes one-cycle rise pulses from synchronised pins
`timescale 1ns/1ps
module rate_meter
    import audio_clk_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    monitor_if.meter  mon
);
    logic [15:0] period_cnt, next_period_cnt;
    logic [11:0] edge_cnt,   next_edge_cnt;
    logic        have_ref,   next_have_ref;
    logic [3:0]  rate_code,  next_rate_code;
    logic [3:0]  ratio_code, next_ratio_code;

    // period to rate code, unmatched gives invalid
    function automatic logic [3:0] rate_of(input logic [15:0] p);
        logic [3:0] code;
        code = INVALID_CODE;
        for (int i = 0; i < RATE_COUNT; i++) begin
            if (p >= RATE_MIN[i] && p <= RATE_MAX[i]) code = 4'(i);
        end
        return code;
    endfunction

    // bit clocks per frame to ratio code
    function automatic logic [3:0] ratio_of(input logic [11:0] n);
        logic [3:0] code;
        code = INVALID_CODE;
        for (int i = 0; i < RATIO_COUNT; i++) begin
            if (n == RATIO_TABLE[i]) code = 4'(i);
        end
        return code;
    endfunction

    // count and classify at each frame start, time out when clocks stop
    always_comb begin
        next_period_cnt = period_cnt;
        next_edge_cnt   = edge_cnt;
        next_have_ref   = have_ref;
        next_rate_code  = rate_code;
        next_ratio_code = ratio_code;
        if (mon.frame_sync_rise) begin
            next_period_cnt = '0;
            next_edge_cnt   = {11'h000, mon.bclk_rise};
            next_have_ref   = 1'b1;
            if (have_ref) begin
                next_rate_code  = rate_of(period_cnt);
                next_ratio_code = ratio_of(edge_cnt);
            end
        end else if (period_cnt >= 16'(TIMEOUT - 1)) begin
            next_have_ref   = 1'b0;
            next_rate_code  = INVALID_CODE;
            next_ratio_code = INVALID_CODE;
        end else begin
            next_period_cnt = period_cnt + 16'h0001;
            if (mon.bclk_rise && edge_cnt != 12'hFFF) next_edge_cnt = edge_cnt + 12'h001;
        end
    end

    // state registers, codes start invalid
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            period_cnt <= '0;
            edge_cnt   <= '0;
            have_ref   <= 1'b0;
            rate_code  <= STATUS_RESET[7:4];
            ratio_code <= STATUS_RESET[3:0];
        end else begin
            period_cnt <= next_period_cnt;
            edge_cnt   <= next_edge_cnt;
            have_ref   <= next_have_ref;
            rate_code  <= next_rate_code;
            ratio_code <= next_ratio_code;
        end
    end

    assign mon.rate_code  = rate_code;
    assign mon.ratio_code = ratio_code;
endmodule

// >>> test/audio_clock_ctrl_monitor.sv
// port checker for the serial audio port clock control
// assumes binding onto audio_clock_ctrl, single clock domain
`timescale 1ns/1ps
module audio_clock_ctrl_monitor
    import audio_clk_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        bit_clk_out,
    input wire logic        bit_clk_oe_out,
    input wire logic        frame_sync_out,
    input wire logic        frame_sync_oe_out,
    input wire logic        root_clk_select_out,
    input wire logic        mclk_ratio_apply_out,
    input wire logic [11:0] mclk_ratio_out,
    input wire logic        mclk_freq_spec_out,
    input wire logic [2:0]  mclk_freq_code_out
);
    logic [7:0] src_copy;
    logic [7:0] next_src_copy;
    logic [2:0] src_ratio;
    logic       src_root;

    // shadow of the source register
    always_comb begin
        next_src_copy = src_copy;
        if (reg_wr_in && reg_addr_in == SOURCE_OFFSET) begin
            next_src_copy = reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            src_copy <= SOURCE_RESET;
        end else begin
            src_copy <= next_src_copy;
        end
    end

    assign src_ratio = src_copy[5:3];
    assign src_root  = src_copy[7];

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read slot");
    AST_RATE_CODE: assert property ($past(reg_rd_in) && $past(reg_addr_in) == STATUS_OFFSET
        |-> reg_rdata_out[7:4] <= 4'h8 || reg_rdata_out[7:4] == 4'hF)
        else $error("reserved rate code seen");
    AST_RATIO_CODE: assert property ($past(reg_rd_in) && $past(reg_addr_in) == STATUS_OFFSET
        |-> reg_rdata_out[3:0] <= 4'hC || reg_rdata_out[3:0] == 4'hF)
        else $error("reserved ratio code seen");
    AST_SRC_READBACK: assert property ($past(reg_rd_in) && $past(reg_addr_in) == SOURCE_OFFSET
        |-> reg_rdata_out == $past(src_copy))
        else $error("source register readback wrong");
    AST_RATIO_MATCH: assert property (mclk_ratio_apply_out
        |-> mclk_ratio_out == MCLK_RATIO_TABLE[$past(src_ratio)])
        else $error("master clock ratio wrong");
    AST_SPEC_CODE: assert property (mclk_freq_spec_out |-> mclk_freq_code_out == $past(src_ratio))
        else $error("frame multiple code wrong");
    AST_ROOT_APPLY: assert property (root_clk_select_out |-> mclk_ratio_apply_out && $past(src_root))
        else $error("root select without its bit");
    AST_OE_PAIR: assert property (bit_clk_oe_out == frame_sync_oe_out)
        else $error("pin enables disagree");
    AST_SLAVE_QUIET: assert property (!bit_clk_oe_out [*3] |-> !bit_clk_out)
        else $error("bit clock generated in slave mode");
    AST_FRAME_EDGE: assert property ($rose(frame_sync_out)
        |-> $changed(bit_clk_out) && bit_clk_out == $past(src_copy[SRC_INVERT_BIT]))
        else $error("frame sync not on chosen bit clock edge");
endmodule

// >>> test/audio_clock_ctrl_tb_top.sv
// testbench for the serial audio port clock control block
// assumes host model and port checker compiled before this file
`timescale 1ns/1ps
module audio_clock_ctrl_tb_top;
    import audio_clk_pkg::*;
    logic        clk_in       = 1'b0;
    logic        rst_b_in     = 1'b0;
    logic [7:0]  reg_addr_in  = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic        host_run     = 1'b0;
    logic [11:0] host_bits    = 12'h040;
    logic [7:0]  reg_rdata_out;
    logic        bit_clk_out, bit_clk_oe_out, frame_sync_out, frame_sync_oe_out;
    logic        root_clk_select_out, mclk_ratio_apply_out, mclk_freq_spec_out;
    logic [11:0] mclk_ratio_out;
    logic [2:0]  mclk_freq_code_out;
    logic        host_bclk, host_frame_sync, bit_clk_in, frame_sync_in;
    logic [11:0] mratio [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
                                12'h300, 12'h400, 12'h600, 12'h900};
    logic [11:0] fbits [5]  = '{12'h040, 12'h028, 12'h018, 12'h020, 12'h010};
    logic [7:0]  fsts [5]   = '{8'h54, 8'hFF, 8'hF1, 8'h62, 8'h70};
    int          err_total  = 0;
    int          tests_run  = 0;

    // pin level from whoever drives it
    assign bit_clk_in    = bit_clk_oe_out ? bit_clk_out : host_bclk;
    assign frame_sync_in = frame_sync_oe_out ? frame_sync_out : host_frame_sync;

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    audio_clock_ctrl #(.TIMEOUT(3000), .BCLK_HALF(2), .FRAME_BITS(16)) DUT (
        .clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .bit_clk_in, .frame_sync_in, .bit_clk_out, .bit_clk_oe_out,
        .frame_sync_out, .frame_sync_oe_out, .root_clk_select_out,
        .mclk_ratio_apply_out, .mclk_ratio_out, .mclk_freq_spec_out, .mclk_freq_code_out);

    audio_host_model HOST (.run_in(host_run), .frame_bits_in(host_bits),
        .bit_clk_out(host_bclk), .frame_sync_out(host_frame_sync));

    task automatic complete_run;
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(n, {4'h0, exp}, {4'h0, d});
    endtask

    // decode outputs land two edges after the write
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    // poll status until it reaches the expected code, bounded
    task automatic wait_sts(input logic [7:0] exp);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 400 && d !== exp; i++) begin
            rd(STATUS_OFFSET, d);
            repeat (50) @(posedge clk_in);
        end
        chk("status", {4'h0, exp}, {4'h0, d});
        if (d !== exp) complete_run();
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd_chk("status reset", STATUS_OFFSET, 8'hFF);
        rd_chk("source reset", SOURCE_OFFSET, 8'h10);
        rd_chk("mode reset", MODE_OFFSET, 8'h02);
        wr(STATUS_OFFSET, 8'h00);
        rd_chk("status read only", STATUS_OFFSET, 8'hFF);
        rd_chk("unmapped", 8'h3C, 8'h00);
        wr(SOURCE_OFFSET, 8'hFA);
        rd_chk("source rw", SOURCE_OFFSET, 8'hFA);
        wr(MODE_OFFSET, 8'h20);
        rd_chk("mode rw", MODE_OFFSET, 8'h20);
        for (int c = 0; c < 8; c++) begin
            wr(SOURCE_OFFSET, {2'b10, c[2:0], 3'b000});
            settle();
            chk("root", 12'h001, {11'h000, root_clk_select_out});
            chk("ratio", mratio[c], mclk_ratio_out);
        end
        wr(SOURCE_OFFSET, 8'h58);
        settle();
        chk("apply", 12'h000, {11'h000, mclk_ratio_apply_out});
        chk("spec code", 12'h00B, {8'h00, mclk_freq_spec_out, mclk_freq_code_out});
        wr(MODE_OFFSET, 8'h05);
        wr(SOURCE_OFFSET, 8'h80);
        settle();
        chk("pll on", 12'h005, {7'h00, root_clk_select_out, mclk_freq_spec_out,
            mclk_freq_code_out});
        wr(SOURCE_OFFSET, 8'hD8);
        wr(MODE_OFFSET, 8'h65);
        settle();
        chk("manual", 12'h005, {7'h00, root_clk_select_out, mclk_freq_spec_out,
            mclk_freq_code_out});
        host_run <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            host_bits <= fbits[k];
            wait_sts(fsts[k]);
        end
        host_run <= 1'b0;
        wait_sts(8'hFF);
        wr(MODE_OFFSET, 8'h80);
        settle();
        chk("oe", 12'h003, {10'h000, bit_clk_oe_out, frame_sync_oe_out});
        chk("master apply", 12'h001, {11'h000, mclk_ratio_apply_out});
        for (int i = 0; i < 400 && frame_sync_in !== 1'b1; i++) @(posedge clk_in);
        chk("frame gen", 12'h001, {11'h000, frame_sync_in});
        chk("edge normal", 12'h000, {11'h000, bit_clk_out});
        wr(SOURCE_OFFSET, 8'h82);
        for (int i = 0; i < 400 && frame_sync_in !== 1'b0; i++) @(posedge clk_in);
        for (int i = 0; i < 400 && frame_sync_in !== 1'b1; i++) @(posedge clk_in);
        chk("edge invert", 12'h003, {10'h000, frame_sync_in, bit_clk_out});
        complete_run();
    end
endmodule

bind audio_clock_ctrl audio_clock_ctrl_monitor MON (
    .clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .bit_clk_out, .bit_clk_oe_out, .frame_sync_out, .frame_sync_oe_out, .root_clk_select_out,
    .mclk_ratio_apply_out, .mclk_ratio_out, .mclk_freq_spec_out, .mclk_freq_code_out);

// >>> test/audio_host_model.sv
// audio host model driving bit clock and frame sync into the port
// assumes 1 ns units; frame length latched at each frame start
`timescale 1ns/1ps
module audio_host_model (
    input  wire logic        run_in,
    input  wire logic [11:0] frame_bits_in,
    output logic             bit_clk_out,
    output logic             frame_sync_out
);
    int n;

    // one frame per pass, both clocks stand still while stopped
    initial begin
        bit_clk_out = 1'b0;
        frame_sync_out = 1'b0;
        #37;
        forever begin
            if (run_in !== 1'b1) begin
                frame_sync_out = 1'b0;
                @(posedge run_in);
            end
            n = int'(frame_bits_in);
            for (int i = 0; i < n; i++) begin
                frame_sync_out = (i == 0); // host drives both clocks
                #80 bit_clk_out = 1'b1;
                #80 bit_clk_out = 1'b0;
            end
        end
    end
endmodule
